/* cbs_pkg.sv */
// constants, types and the input synchroniser of the cpu bus cycle sequencer
// How it works
// [RULE1] fetch T1: program counter out, fetch strobes low
// [RULE2] stall sampled at T2 and stall fall
// [RULE3] opcode latched entering T3, strobes released
// [RULE4] T3 refresh: vector page, counter, strobe, request
// [RULE5] read strobe stays high during refresh
// [RULE6] bit7 enabled: refresh address spans 00 to FF
// [RULE7] bit7 pin follows address bit outside refresh
// [RULE8] T4 request high, refresh held to T1
// [RULE9] stall mechanism shared by all cycle kinds
// [RULE10] memory read: address, request, read strobe
// [RULE11] memory write: data driven, write strobe T2
// [RULE12] io cycles always add one auto stall
// [RULE13] io stall first sampled at auto stall
// [RULE14] io address: port low, register high
// [RULE15] io input: io request and read in T2
// [RULE16] io output: data from T1, strobes T2
// [RULE17] hold sampled at last state, bus floats
// [RULE18] hold rechecked each hold state, then resume
// [RULE19] hold grant low while bus floats
// [RULE20] no refresh while floated, strobe high
// [RULE21] alternate master refreshes during long holds
// [RULE22] no interrupt acceptance while floated
// [RULE23] address stable before memory request falls
// [RULE24] fetch four states, others three, before stalls
// [RULE25] refresh counter low seven bits step per fetch
`timescale 1ns/1ns
`default_nettype none

package cbs_pkg;

   // ----------------------------------------------------------------
   // cycle kinds, states and bundles
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {CBS_FETCH, CBS_MEM_RD, CBS_MEM_WR, CBS_IO_RD, CBS_IO_WR} cbs_kind_t;

   typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_TW, S_TWA, S_T3, S_T4, S_HOLD} cbs_state_t;

   typedef struct packed {
      cbs_kind_t kind;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cbs_cmd_t;

   typedef struct packed {
      logic valid;
      logic opcode;
      logic [7:0] data;
   } cbs_rsp_t;

   typedef struct packed {
      logic fetch_cycle_n;
      logic mem_request_n;
      logic io_request_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic refresh_strobe_n;
   } cbs_ctrl_t;

   // ----------------------------------------------------------------
   // values after reset and phase codes
   // ----------------------------------------------------------------
   localparam cbs_ctrl_t CBS_CTRL_IDLE = 6'h3F;
   localparam logic [7:0] CBS_REFRESH_RESET = 8'h00;
   localparam logic [15:0] CBS_ADDR_RESET = 16'h0000;
   localparam logic [7:0] CBS_DATA_RESET = 8'h00;
   localparam logic CBS_PHASE_HIGH = 1'b0;
   localparam logic CBS_PHASE_LOW = 1'b1;
   localparam logic [1:0] CBS_PINS_IDLE = 2'h3;
   localparam int CBS_CLKS_PER_STATE = 2;
   localparam int CBS_FETCH_STATES = 4;
   localparam int CBS_XFER_STATES = 3;

endpackage : cbs_pkg

`default_nettype wire

`default_nettype none

// ----------------------------------------------------------------
// three stage synchroniser, change taken when stages two and three agree
// ----------------------------------------------------------------
module cbs_sync3
   import cbs_pkg::*;
#(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;

   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
         o_level <= RESET_VAL;
      end
      else
      begin
         stage1 <= i_async;
         stage2 <= stage1;
         stage3 <= stage2;
         o_level <= (agree & stage3) | (~agree & o_level);
      end
   end
endmodule : cbs_sync3

`default_nettype wire

/* cbs_sequencer.sv */
// external bus cycle sequencer: fetch with refresh, memory, io and bus hold
`timescale 1ns/1ns
`default_nettype none

module cbs_sequencer
   import cbs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   // user side
   input wire logic i_cmd_valid,
   input wire cbs_cmd_t i_cmd,
   output logic o_cmd_taken,
   output cbs_rsp_t o_rsp,
   input wire logic [7:0] i_vector_page,
   input wire logic i_refresh_load,
   input wire logic [7:0] i_refresh_value,
   input wire logic i_refresh_bit7_en,
   output logic o_int_accept_en,
   // pins
   output logic [15:0] o_addr,
   output logic o_addr_oe,
   output logic o_refresh_addr_bit7,
   output logic [7:0] o_data,
   output logic o_data_oe,
   input wire logic [7:0] i_data,
   output cbs_ctrl_t o_ctrl,
   output logic o_ctrl_oe,
   input wire logic i_stall_request_n,
   input wire logic i_hold_request_n,
   output logic o_hold_grant_n
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cbs_state_t state;
   cbs_state_t next_state;
   logic phase;
   // the command in flight; kind, address and write data hold until the
   // edge that opens the next T1
   cbs_cmd_t cmd;
   logic stall_seen;
   logic hold_pend;
   logic refresh_linger;
   logic [7:0] refresh_counter;

   logic [1:0] pins_sync;
   logic stall_low;
   logic hold_low;

   // stall and hold come straight from pins, so they cross into this clock
   // through the filter; expect three to four clocks of lag
   cbs_sync3 #(
      .WIDTH(2),
      .RESET_VAL(CBS_PINS_IDLE)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_stall_request_n, i_hold_request_n}),
      .o_level(pins_sync)
   );

   assign stall_low = ~pins_sync[1];
   assign hold_low = ~pins_sync[0];

   // ----------------------------------------------------------------
   // decode of state, half state and cycle kind
   // ----------------------------------------------------------------
   wire ph_hi = (phase == CBS_PHASE_HIGH);
   wire ph_lo = (phase == CBS_PHASE_LOW);
   wire k_fetch = (cmd.kind == CBS_FETCH);
   wire k_mem_rd = (cmd.kind == CBS_MEM_RD);
   wire k_mem_wr = (cmd.kind == CBS_MEM_WR);
   wire k_io_rd = (cmd.kind == CBS_IO_RD);
   wire k_io_wr = (cmd.kind == CBS_IO_WR);
   wire k_io = k_io_rd | k_io_wr;
   wire k_mem = k_mem_rd | k_mem_wr;
   wire t1 = (state == S_T1);
   wire t2 = (state == S_T2);
   wire tw = (state == S_TW);
   wire twa = (state == S_TWA);
   wire t3 = (state == S_T3);
   wire t4 = (state == S_T4);
   wire in_idle = (state == S_IDLE);
   wire in_hold = (state == S_HOLD);
   wire in_access = t2 | tw | twa;
   wire in_cycle = t1 | in_access | t3 | t4;

   // last state of a machine cycle: T4 for a fetch, T3 otherwise
   wire last_state = (k_fetch & t4) | (~k_fetch & t3);                          // [RULE24]
   wire cycle_end = last_state & ph_lo;
   wire fetch_refresh_done = k_fetch & cycle_end;

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   // every bus state is two clocks, phase high then phase low; the state moves
   // only at the end of the low half, so stall and hold are looked at one
   // clock earlier, at the end of the high half
   // stall sampled at the falling edge of T2 and of each stall; io T2 ignores it
   wire stall_sample = ph_hi & ((t2 & ~k_io) | tw | twa);                      // [RULE2] [RULE9]
   wire hold_sample = ph_hi & last_state;                                      // [RULE17]
   wire take_cmd = i_cmd_valid & ~hold_low;

   always_comb
   begin
      next_state = state;
      if (ph_lo)
      begin
         unique case (state)
            S_IDLE:
            begin
               if (hold_low)
                  next_state = S_HOLD;
               else if (take_cmd)
                  next_state = S_T1;
            end
            S_T1: next_state = S_T2;
            S_T2:
            begin
               if (k_io)
                  next_state = S_TWA;                                          // [RULE12]
               else if (stall_seen)
                  next_state = S_TW;                                           // [RULE2]
               else
                  next_state = S_T3;
            end
            S_TW: next_state = stall_seen ? S_TW : S_T3;                        // [RULE9]
            S_TWA: next_state = stall_seen ? S_TW : S_T3;                       // [RULE13]
            S_T3:
            begin
               if (k_fetch)
                  next_state = S_T4;
               else if (hold_pend)
                  next_state = S_HOLD;                                         // [RULE17]
               else if (i_cmd_valid)
                  next_state = S_T1;
               else
                  next_state = S_IDLE;
            end
            S_T4:
            begin
               if (hold_pend)
                  next_state = S_HOLD;                                         // [RULE17]
               else if (i_cmd_valid)
                  next_state = S_T1;
               else
                  next_state = S_IDLE;
            end
            S_HOLD: next_state = hold_low ? S_HOLD : S_IDLE;                    // [RULE18]
         endcase
      end
   end

   // a command is latched only on the edge that opens T1
   wire enter_t1 = ph_lo & (next_state == S_T1) & (state != S_T1);

   // refresh counter: software load wins over the step
   // it steps once per fetch, at the close of T4
   wire [7:0] refresh_step = i_refresh_bit7_en ? (refresh_counter + 8'h01)     // [RULE6]
                           : {refresh_counter[7], refresh_counter[6:0] + 7'h01}; // [RULE25]

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state <= S_IDLE;
         phase <= CBS_PHASE_HIGH;
         cmd <= '0;
         stall_seen <= 1'b0;
         hold_pend <= 1'b0;
         refresh_linger <= 1'b0;
         refresh_counter <= CBS_REFRESH_RESET;
      end
      else
      begin
         state <= next_state;
         phase <= ~phase;
         if (enter_t1)
            cmd <= i_cmd;
         if (stall_sample)
            stall_seen <= stall_low;
         if (hold_sample)
            hold_pend <= hold_low;
         if (fetch_refresh_done & ~hold_pend)
            refresh_linger <= 1'b1;                                            // [RULE8]
         else if (t1 | in_hold)
            refresh_linger <= 1'b0;
         if (i_refresh_load)
            refresh_counter <= i_refresh_value;
         else if (fetch_refresh_done)
            refresh_counter <= refresh_step;                                   // [RULE25]
      end
   end

   // ----------------------------------------------------------------
   // strobe decode
   // ----------------------------------------------------------------
   // strobes are decoded a clock ahead and registered, so pins lag state by one
   // memory request falls in the second half of T1, after the address settles; io request falls in T2
   wire fetch_mem_request_n = k_fetch & ((t1 & ph_lo) | in_access | (t3 & ph_lo) | (t4 & ph_hi)); // [RULE1] [RULE4] [RULE8] [RULE23]
   wire fetch_rd = k_fetch & ((t1 & ph_lo) | in_access);                       // [RULE3] [RULE5]
   wire fetch_m1 = k_fetch & (t1 | in_access);                                 // [RULE1] [RULE3]
   wire refresh_on = (k_fetch & (t3 | t4)) | (refresh_linger & in_idle);       // [RULE4] [RULE8] [RULE20]
   wire mem_mem_request_n = k_mem & ((t1 & ph_lo) | in_access | (t3 & ph_hi));         // [RULE10] [RULE23]
   wire mem_rd = k_mem_rd & ((t1 & ph_lo) | in_access | (t3 & ph_hi));         // [RULE10]
   wire mem_wr = k_mem_wr & ((t2 & ph_lo) | tw | (t3 & ph_hi));                // [RULE11]
   wire io_req = k_io & (in_access | (t3 & ph_hi));                            // [RULE15] [RULE16]
   wire io_rd = k_io_rd & (in_access | (t3 & ph_hi));                          // [RULE15]
   wire io_wr = k_io_wr & (in_access | (t3 & ph_hi));                          // [RULE16]

   // all strobes are active low
   cbs_ctrl_t next_ctrl;
   assign next_ctrl.fetch_cycle_n = ~fetch_m1;
   assign next_ctrl.mem_request_n = ~(fetch_mem_request_n | mem_mem_request_n);
   assign next_ctrl.io_request_n = ~io_req;
   assign next_ctrl.read_strobe_n = ~(fetch_rd | mem_rd | io_rd);
   assign next_ctrl.write_strobe_n = ~(mem_wr | io_wr);
   assign next_ctrl.refresh_strobe_n = ~(refresh_on & ~in_hold);               // [RULE20]

   // ----------------------------------------------------------------
   // address and data decode
   // ----------------------------------------------------------------
   // write data is driven from T1 so that it settles before the write strobe
   // io commands carry the port in the low byte and the register in the high byte
   wire [15:0] refresh_addr = {i_vector_page, refresh_counter};                // [RULE4] [RULE6]
   wire [15:0] next_addr = refresh_on ? refresh_addr : cmd.addr;               // [RULE1] [RULE14]
   wire next_bit7 = refresh_on ? refresh_counter[7] : cmd.addr[7];             // [RULE7]
   wire next_data_oe = (k_mem_wr | k_io_wr) & (t1 | in_access | t3);           // [RULE11] [RULE16]
   wire next_bus_oe = ~in_hold;                                                // [RULE17] [RULE18]

   // read data is taken raw from the pins; the far side must hold it steady
   // around the capture edge, as the data bus has no synchroniser
   // opcode taken on entry to T3, data reads at the falling edge of T3
   wire cap_fetch = k_fetch & ph_lo & (next_state == S_T3) & (t2 | tw);        // [RULE3]
   wire cap_read = (k_mem_rd | k_io_rd) & t3 & ph_hi;                          // [RULE10] [RULE15]

   cbs_rsp_t next_rsp;
   assign next_rsp.valid = cap_fetch | cap_read;
   assign next_rsp.opcode = cap_fetch;
   assign next_rsp.data = i_data;

   // ----------------------------------------------------------------
   // address pins
   // ----------------------------------------------------------------
   // the refresh address stays frozen while the strobe lingers in idle,
   // because the counter has already stepped by then; in hold the pins
   // float and keep their last value
   wire addr_keep = in_idle & refresh_linger;                                  // [RULE8]
   wire addr_load = (in_cycle | in_idle) & ~addr_keep;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_addr <= CBS_ADDR_RESET;
         o_refresh_addr_bit7 <= 1'b0;
      end
      else if (addr_load)
      begin
         o_addr <= next_addr;                                                   // [RULE1] [RULE14]
         o_refresh_addr_bit7 <= next_bit7;                                      // [RULE7]
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_cmd_taken <= 1'b0;
         o_rsp <= '0;
         o_int_accept_en <= 1'b1;
         o_addr_oe <= 1'b1;
         o_data <= CBS_DATA_RESET;
         o_data_oe <= 1'b0;
         o_ctrl <= CBS_CTRL_IDLE;
         o_ctrl_oe <= 1'b1;
         o_hold_grant_n <= 1'b1;
      end
      else
      begin
         o_cmd_taken <= enter_t1;
         o_rsp <= next_rsp;
         o_int_accept_en <= ~in_hold;                                          // [RULE22]
         o_addr_oe <= next_bus_oe;                                             // [RULE17]
         o_data <= cmd.wdata;
         o_data_oe <= next_data_oe & next_bus_oe;
         o_ctrl <= next_ctrl;
         o_ctrl_oe <= next_bus_oe;
         o_hold_grant_n <= ~in_hold;                                           // [RULE19]
      end
   end

endmodule : cbs_sequencer

`default_nettype wire

/* cbs_sequencer_props.sv */
// concurrent checks on the pins of the bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module cbs_sequencer_props
   import cbs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_vector_page,
   input wire logic [15:0] o_addr,
   input wire logic o_addr_oe,
   input wire logic o_refresh_addr_bit7,
   input wire logic o_data_oe,
   input wire cbs_ctrl_t o_ctrl,
   input wire logic o_ctrl_oe,
   input wire logic o_hold_grant_n,
   input wire logic o_int_accept_en
);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic seen;
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         seen <= 1'b0;
      else if (!o_ctrl.fetch_cycle_n)
         seen <= 1'b1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_FETCH_T1: assert property ($fell(o_ctrl.fetch_cycle_n) |-> o_ctrl.mem_request_n
      ##1 (!o_ctrl.mem_request_n && !o_ctrl.read_strobe_n)) else $error("fetch strobes");
   AST_FETCH_LEN: assert property ($fell(o_ctrl.fetch_cycle_n) |-> (!o_ctrl.fetch_cycle_n)[*4])
      else $error("fetch too short");
   AST_REFRESH: assert property ($fell(o_ctrl.refresh_strobe_n) |-> (o_ctrl.fetch_cycle_n
      && o_ctrl.mem_request_n && o_addr[15:8] == i_vector_page) ##1 (!o_ctrl.mem_request_n
      && !o_ctrl.refresh_strobe_n)[*2] ##1 (o_ctrl.mem_request_n && !o_ctrl.refresh_strobe_n))
      else $error("refresh sequence");
   AST_REFRESH_STROBE_N_NO_RD: assert property (!o_ctrl.refresh_strobe_n |-> o_ctrl.read_strobe_n)
      else $error("read during refresh");
   AST_REFRESH_STROBE_N_HOLD: assert property (!o_ctrl.refresh_strobe_n && !$past(o_ctrl.refresh_strobe_n)
      |-> $stable(o_addr) && $stable(o_refresh_addr_bit7)) else $error("refresh address moved");
   AST_BIT7: assert property (seen && o_ctrl_oe && o_ctrl.refresh_strobe_n
      |-> o_refresh_addr_bit7 == o_addr[7]) else $error("bit7 pin");
   AST_ADDR_STABLE: assert property ($fell(o_ctrl.mem_request_n) |-> $stable(o_addr))
      else $error("address moved at request");
   AST_IO_LEN: assert property ($fell(o_ctrl.io_request_n) |-> (o_ctrl.read_strobe_n
      != o_ctrl.write_strobe_n && o_ctrl.mem_request_n) ##0 (!o_ctrl.io_request_n)[*5])
      else $error("io cycle");
   AST_WRITE: assert property (!o_ctrl.write_strobe_n |-> o_ctrl.read_strobe_n && o_data_oe)
      else $error("write without data");
   AST_HOLD_FLOAT: assert property (!o_hold_grant_n |-> !o_addr_oe && !o_data_oe && !o_ctrl_oe)
      else $error("bus not floated");
   AST_HOLD_QUIET: assert property (!o_hold_grant_n |-> o_ctrl.refresh_strobe_n
      && !o_int_accept_en) else $error("hold quiet");
endmodule : cbs_sequencer_props
`default_nettype wire

/* cbs_bus_model.sv */
// memory and peripheral model on the far side of the bus
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_model
   import cbs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic [15:0] i_addr,
   input wire cbs_ctrl_t i_ctrl,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_stall_request_n,
   output logic [15:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic o_wr_io,
   output logic [7:0] o_wr_cnt
);
   // ----------------------------------------------------------------
   // read answer, stall and write capture
   // ----------------------------------------------------------------
   logic [7:0] last = 8'h00;
   logic [4:0] cnt = 5'h00;
   logic wr_q = 1'b1;
   wire logic drive = !i_ctrl.read_strobe_n && (!i_ctrl.mem_request_n || !i_ctrl.io_request_n);
   // released bus shows the inverse of the last value
   assign o_rdata = drive ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A) : ~last;
   assign o_stall_request_n = !(i_slow && cnt < 5'h10);
   initial o_wr_cnt = 8'h00;
   always @(posedge i_clk)
   begin
      last <= o_rdata;
      cnt <= !i_slow ? 5'h00 : (cnt == 5'h1F ? cnt : cnt + 5'h01);
      wr_q <= i_ctrl.write_strobe_n;
      if (!i_ctrl.write_strobe_n)
      begin
         o_wr_addr <= i_addr;
         o_wr_data <= i_wdata;
         o_wr_io <= !i_ctrl.io_request_n;
      end
      if (!wr_q && i_ctrl.write_strobe_n)
         o_wr_cnt <= o_wr_cnt + 8'h01;
   end
endmodule : cbs_bus_model
`default_nettype wire

/* cbs_sequencer_tb.sv */
// self-checking testbench of the bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module cbs_sequencer_tb
   import cbs_pkg::*;
;
   // ----------------------------------------------------------------
   // signals, design and far side
   // ----------------------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, vld = 1'b0, rload = 1'b0, b7en = 1'b1, hold_n = 1'b1, slow = 1'b0;
   cbs_cmd_t cmd = '0;
   logic [7:0] vpage = 8'hA5, rval = 8'h00, dout, rdata, wd, wcnt, rf_lo;
   logic taken, int_en, addr_oe, b7, dout_oe, ctrl_oe, grant_n, stall_n, wio, rfq, tk;
   logic [15:0] addr, wa;
   cbs_rsp_t rsp;
   cbs_ctrl_t ctrl;
   int n_errors = 0, tests_run = 0, cycles = 0, lat, l0, n;
   wire logic [7:0] bus = dout_oe ? dout : rdata;
   cbs_sequencer i_dut (.i_clk(clk), .i_rst(rst), .i_cmd_valid(vld), .i_cmd(cmd),
      .o_cmd_taken(taken), .o_rsp(rsp), .i_vector_page(vpage), .i_refresh_load(rload),
      .i_refresh_value(rval), .i_refresh_bit7_en(b7en), .o_int_accept_en(int_en),
      .o_addr(addr), .o_addr_oe(addr_oe), .o_refresh_addr_bit7(b7), .o_data(dout),
      .o_data_oe(dout_oe), .i_data(bus), .o_ctrl(ctrl), .o_ctrl_oe(ctrl_oe),
      .i_stall_request_n(stall_n), .i_hold_request_n(hold_n), .o_hold_grant_n(grant_n));
   cbs_bus_model i_mem (.i_clk(clk), .i_slow(slow), .i_addr(addr), .i_ctrl(ctrl),
      .i_wdata(dout), .o_rdata(rdata), .o_stall_request_n(stall_n), .o_wr_addr(wa),
      .o_wr_data(wd), .o_wr_io(wio), .o_wr_cnt(wcnt));
   initial forever #25 clk = ~clk;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task print_verdict;
      if (n_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function logic [7:0] rd_exp(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction : rd_exp
   function logic [7:0] rf_next(input logic [7:0] v, input logic en);
      return en ? v + 8'h01 : {v[7], v[6:0] + 7'h01};
   endfunction : rf_next
   task run(input cbs_kind_t k, input logic [15:0] a, input logic [7:0] w);
      logic [7:0] c0;
      c0 = wcnt;
      cmd <= '{k, a, w};
      vld <= 1'b1;
      lat = 0;
      while (taken !== 1'b1 && lat < 300)
      begin
         @(negedge clk);
         lat++;
      end
      vld <= 1'b0;
      while (rsp.valid !== 1'b1 && wcnt === c0 && lat < 300)
      begin
         @(negedge clk);
         lat++;
      end
      chk("done", 1, lat < 300);
      if (k == CBS_MEM_WR || k == CBS_IO_WR)
      begin
         chk("wr addr", a, wa);
         chk("wr data", w, wd);
         chk("wr io", k == CBS_IO_WR, wio);
      end
      else
      begin
         chk("rd data", rd_exp(a), rsp.data);
         chk("opcode", k == CBS_FETCH, rsp.opcode);
      end
   endtask : run
   always @(posedge clk)
   begin
      cycles++;
      rfq <= ctrl.refresh_strobe_n;
      if (rfq && !ctrl.refresh_strobe_n)
         rf_lo <= {b7, addr[6:0]};
      if (cycles > 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h94BB));
      repeat (20) @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      for (int i = 0; i < 2; i++)
      begin
         b7en <= (i == 0);
         rval <= (i == 0) ? 8'h7F : 8'hFF;
         rload <= 1'b1;
         @(negedge clk);
         rload <= 1'b0;
         run(CBS_FETCH, 16'h0100, 8'h00);
         repeat (4) @(negedge clk);
         chk("refresh addr", rval, rf_lo);
         run(CBS_FETCH, 16'h0101, 8'h00);
         repeat (4) @(negedge clk);
         chk("refresh step", rf_next(rval, b7en), rf_lo);
      end
      for (int i = 0; i < 2; i++)
      begin
         run(i ? CBS_IO_RD : CBS_FETCH, 16'h3C42, 8'h00);
         l0 = lat;
         slow <= 1'b1;
         repeat (6) @(negedge clk);
         run(i ? CBS_IO_RD : CBS_FETCH, 16'h3C42, 8'h00);
         slow <= 1'b0;
         chk("stall", 1, lat > l0);
         @(negedge clk);
      end
      hold_n <= 1'b0; // brief hold, so the alternate master owes no refresh
      n = 0;
      while (grant_n !== 1'b0 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk("grant", 0, grant_n);
      chk("hold refresh_strobe_n", 1, ctrl.refresh_strobe_n);
      chk("hold int", 0, int_en);
      cmd <= '{CBS_FETCH, 16'h0200, 8'h00};
      vld <= 1'b1;
      tk = 1'b0;
      repeat (10)
      begin
         @(negedge clk);
         tk = tk | (taken === 1'b1);
      end
      chk("held cmd", 0, tk);
      hold_n <= 1'b1;
      n = 0;
      while (grant_n !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk("release", 1, grant_n);
      run(CBS_FETCH, 16'h0200, 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         slow <= 1'($urandom_range(1, 0));
         run(cbs_kind_t'($urandom_range(4, 0)), 16'($urandom), 8'($urandom));
         slow <= 1'b0;
         @(negedge clk);
      end
      print_verdict();
   end
endmodule : cbs_sequencer_tb
bind cbs_sequencer cbs_sequencer_props i_props (.i_clk(i_clk), .i_rst(i_rst),
   .i_vector_page(i_vector_page), .o_addr(o_addr), .o_addr_oe(o_addr_oe),
   .o_refresh_addr_bit7(o_refresh_addr_bit7), .o_data_oe(o_data_oe), .o_ctrl(o_ctrl),
   .o_ctrl_oe(o_ctrl_oe), .o_hold_grant_n(o_hold_grant_n), .o_int_accept_en(o_int_accept_en));
`default_nettype wire
